// ===== bench/ppsl_board_model.sv
// Board model: port power switches with pull-ups and fault injection
`timescale 1ns/1ps
module ppsl_board_model (
  input  wire logic [1:0] en_in,
  input  wire logic [1:0] oe_in,
  input  wire logic [1:0] fault_in,
  output logic      [1:0] sense_n_out,
  output logic      [1:0] ctl_pin_out
);
  // Released pin sits on its pull-up unless the switch flags a fault
  assign ctl_pin_out = (oe_in & en_in) | (~oe_in & ~fault_in);
  assign sense_n_out = ~fault_in;
endmodule

// ===== bench/ppsl_port_power_properties.sv
// Checker for the port power and strap latch block
`timescale 1ns/1ps
`include "ppsl_defines.svh"
module ppsl_port_power_properties (
  input wire logic                 clk_sys_in,
  input wire logic                 reset_n_in,
  input wire logic                 smbus_wr_in,
  input wire ppsl_pkg::ppsl_addr_t smbus_addr_in,
  input wire ppsl_pkg::ppsl_byte_t smbus_wdata_in,
  input wire logic                 otp_wr_in,
  input wire ppsl_pkg::ppsl_addr_t otp_addr_in,
  input wire ppsl_pkg::ppsl_byte_t otp_wdata_in,
  input wire logic                 rd_in,
  input wire ppsl_pkg::ppsl_addr_t rd_addr_in,
  input wire ppsl_pkg::ppsl_byte_t rd_data_out,
  input wire logic [1:0]           port_power_request_in,
  input wire logic [1:0]           combined_control_sel_in,
  input wire logic [1:0]           overcurrent_out,
  input wire logic [1:0]           charging_enable_out,
  input wire logic                 self_powered_out,
  input wire logic                 configuring_out,
  input wire logic                 self_power_detect_in,
  input wire logic                 port1_overcurrent_sense_n_in,
  input wire logic                 port1_power_enable_oe_out,
  input wire logic                 port2_power_enable_out
);
  import ppsl_pkg::*;
  logic       seen_reg;
  ppsl_byte_t dyn_reg;
  wire        run = seen_reg && !configuring_out;
  wire        dyn = dyn_reg == `PPSL_DYN_PWR_ENABLE;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) seen_reg <= 1'h0;
    else if (configuring_out) seen_reg <= 1'h1;
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) dyn_reg <= `PPSL_DYN_PWR_RESET;
    else if (smbus_wr_in && smbus_addr_in == `PPSL_DYN_PWR_ADDR) dyn_reg <= smbus_wdata_in;
    else if (otp_wr_in && otp_addr_in == `PPSL_DYN_PWR_ADDR) dyn_reg <= otp_wdata_in;
  end
  default clocking dcb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // ==========================================================
  // Self-power detect
  sequence cfg_steady;
    (configuring_out && $stable(self_power_detect_in))[*5];
  endsequence
  sequence dyn_steady;
    (run && dyn && $stable(self_power_detect_in))[*5];
  endsequence
  a_cfg_sample: assert property (cfg_steady |-> self_powered_out == self_power_detect_in)
    else $error("self power not sampled in config");
  a_dyn_follow: assert property (dyn_steady |-> self_powered_out == self_power_detect_in)
    else $error("self power not followed");
  a_self_hold: assert property (run && $past(run) && !dyn && !$past(dyn) |-> $stable(self_powered_out))
    else $error("self power changed");
  // ==========================================================
  // Power, sense, straps, register
  a_pwr_on: assert property (run && port_power_request_in[1] && !combined_control_sel_in[1]
    |=> port2_power_enable_out || combined_control_sel_in[1]) else $error("port2 not powered");
  a_comb_release: assert property (run && combined_control_sel_in[0] && port_power_request_in[0]
    |=> !port1_power_enable_oe_out || !combined_control_sel_in[0]) else $error("pin not released");
  a_oc_sense: assert property ((!combined_control_sel_in[0] &&
    $stable(port1_overcurrent_sense_n_in))[*5] |-> overcurrent_out[0] == !port1_overcurrent_sense_n_in)
    else $error("overcurrent wrong");
  a_strap_hold: assert property (seen_reg |=> $stable(charging_enable_out))
    else $error("straps changed");
  a_reg_read: assert property (rd_in |=> rd_data_out ==
    (($past(rd_addr_in) == `PPSL_DYN_PWR_ADDR) ? $past(dyn_reg) : 8'h00)) else $error("bad read");
endmodule

// ===== bench/tb.sv
// Testbench for the port power and strap latch block
`timescale 1ns/1ps
`include "ppsl_defines.svh"
module tb;
  import ppsl_pkg::*;
  logic       clk_sys_in = 1'h0, reset_n_in = 1'h0, swr = 1'h0, owr = 1'h0, rd = 1'h0;
  logic       done = 1'h0, spd = 1'h0, used = 1'h0, sp, cfg, p1, p1oe, p2, p2oe;
  logic [1:0] fs = 2'h1;
  ppsl_addr_t sa = 16'h0, oa = 16'h0, ra = 16'h0;
  ppsl_byte_t sd = 8'h0, od = 8'h0, rdat;
  logic [1:0] req = 2'h0, sel = 2'h0, bc = 2'h0, fault = 2'h0, chg, oc, fdo, ctl, sn;
  int         bad_count = 0, num_checks = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  ppsl_port_power ppsl_port_power_inst (.clk_sys_in, .reset_n_in, .smbus_wr_in(swr),
    .smbus_addr_in(sa), .smbus_wdata_in(sd), .otp_wr_in(owr), .otp_addr_in(oa),
    .otp_wdata_in(od), .rd_in(rd), .rd_addr_in(ra), .rd_data_out(rdat),
    .port_power_request_in(req), .combined_control_sel_in(sel), .config_done_in(done),
    .self_power_detect_used_in(used), .fixed_device_cfg_in(2'h2), .overcurrent_out(oc),
    .charging_enable_out(chg), .self_powered_out(sp), .fixed_device_out(fdo),
    .configuring_out(cfg), .self_power_detect_in(spd), .fixed_device_straps_in(fs),
    .port1_charging_strap_in(bc[0]), .port2_charging_strap_in(bc[1]),
    .port1_overcurrent_sense_n_in(sn[0]), .port2_overcurrent_sense_n_in(sn[1]),
    .port1_combined_control_in(ctl[0]), .port2_combined_control_in(ctl[1]),
    .port1_power_enable_out(p1), .port1_power_enable_oe_out(p1oe),
    .port2_power_enable_out(p2), .port2_power_enable_oe_out(p2oe));
  ppsl_board_model ppsl_board_model_inst (.en_in({p2, p1}), .oe_in({p2oe, p1oe}),
    .fault_in(fault), .sense_n_out(sn), .ctl_pin_out(ctl));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (e !== g) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic wr(logic otp, ppsl_addr_t a, ppsl_byte_t d);
    swr <= !otp;
    owr <= otp;
    sa <= a;
    oa <= a;
    sd <= d;
    od <= d;
    cyc(1);
    swr <= 1'h0;
    owr <= 1'h0;
  endtask
  task automatic rdc(ppsl_addr_t a, ppsl_byte_t e);
    rd <= 1'h1;
    ra <= a;
    cyc(1);
    rd <= 1'h0;
    cyc(1);
    chk("register", e, rdat);
  endtask
  task automatic boot(logic [1:0] s);
    reset_n_in <= 1'h0;
    bc <= s;
    done <= 1'h0;
    cyc(8);
    reset_n_in <= 1'h1;
    cyc(8);
    chk("charging", {6'h0, s}, {6'h0, chg});
  endtask
  task automatic t_straps;
    boot(2'h1);
    chk("fixed strap", 8'h1, {6'h0, fdo});
    bc <= 2'h2;
    cyc(6);
    chk("charging held", 8'h1, {6'h0, chg});
    boot(2'h2);
    $display("test straps done");
  endtask
  task automatic t_cfg;
    spd <= 1'h1;
    used <= 1'h1;
    boot(2'h3);
    chk("configuring", 8'h1, {7'h0, cfg});
    chk("self power", 8'h1, {7'h0, sp});
    chk("fixed", 8'h2, {6'h0, fdo});
    done <= 1'h1;
    cyc(2);
    spd <= 1'h0;
    cyc(8);
    chk("configured", 8'h0, {7'h0, cfg});
    chk("self power held", 8'h1, {7'h0, sp});
    $display("test config done");
  endtask
  task automatic t_reg;
    rdc(16'h4134, 8'hc1);
    wr(1'h0, 16'h4135, 8'h41);
    rdc(16'h4135, 8'h00);
    chk("unmapped write", 8'h1, {7'h0, sp});
    wr(1'h1, 16'h4134, 8'h41);
    rdc(16'h4134, 8'h41);
    cyc(6);
    chk("dynamic", 8'h0, {7'h0, sp});
    wr(1'h0, 16'h4134, 8'hc1);
    spd <= 1'h1;
    rdc(16'h4134, 8'hc1);
    cyc(6);
    chk("static again", 8'h0, {7'h0, sp});
    $display("test register done");
  endtask
  task automatic t_pwr;
    req <= 2'h3;
    fault <= 2'h1;
    cyc(6);
    chk("power", 8'h3, {6'h0, p2, p1});
    chk("overcurrent", 8'h1, {6'h0, oc});
    sel <= 2'h3;
    cyc(6);
    chk("combined on", 8'h0, {4'h0, p2oe, p1oe, p2, p1});
    chk("combined fault", 8'h1, {6'h0, oc});
    req <= 2'h0;
    cyc(6);
    chk("combined off", 8'hc, {4'h0, p2oe, p1oe, p2, p1});
    fault <= 2'h0;
    req <= 2'h3;
    repeat (4) begin
      cyc(1);
      chk("combined release", 8'h0, {6'h0, oc});
    end
    fault <= 2'h2;
    cyc(6);
    chk("port2 fault", 8'h2, {6'h0, oc});
    $display("test power done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    t_straps();
    t_cfg();
    t_reg();
    t_pwr();
    final_report();
  end
  initial begin
    #200000;
    bad_count++;
    final_report();
  end
endmodule
bind ppsl_port_power ppsl_port_power_properties ppsl_port_power_properties_inst (.*);

// ===== rtl/ppsl_defines.svh
// Constants for the port power and strap latch block
`ifndef PPSL_DEFINES_SVH
`define PPSL_DEFINES_SVH

// ============================================================
// Register map
`define PPSL_DYN_PWR_ADDR      16'h4134
`define PPSL_DYN_PWR_RESET     8'hc1
`define PPSL_DYN_PWR_ENABLE    8'h41

// ============================================================
// Pin levels
`define PPSL_PWR_OFF           1'b0
`define PPSL_PWR_ON            1'b1
`define PPSL_STRAP_DISABLED    1'b0
`define PPSL_STRAP_ENABLED     1'b1
`define PPSL_SELF_POWERED      1'b1

`endif

// ===== rtl/ppsl_pkg.sv
// Types shared by the port power and strap latch block
package ppsl_pkg;
  typedef enum logic [1:0] {
    PPSL_RESET_ST  = 2'b00,
    PPSL_CONFIG_ST = 2'b01,
    PPSL_RUN_ST    = 2'b11
  } ppsl_state_e;

  typedef logic [7:0]  ppsl_byte_t;
  typedef logic [15:0] ppsl_addr_t;
endpackage

// ===== rtl/ppsl_port_power.sv
// Port power enables, strap latching and local-power detect
`timescale 1ns/1ps
`include "ppsl_defines.svh"

module ppsl_port_power (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_n_in,
  // Register write ports (management port and start-up memory) and read port
  input  wire logic             smbus_wr_in,
  input  wire ppsl_pkg::ppsl_addr_t smbus_addr_in,
  input  wire ppsl_pkg::ppsl_byte_t smbus_wdata_in,
  input  wire logic             otp_wr_in,
  input  wire ppsl_pkg::ppsl_addr_t otp_addr_in,
  input  wire ppsl_pkg::ppsl_byte_t otp_wdata_in,
  input  wire logic             rd_in,
  input  wire ppsl_pkg::ppsl_addr_t rd_addr_in,
  output ppsl_pkg::ppsl_byte_t  rd_data_out,
  // Core side
  input  wire logic [1:0]       port_power_request_in,
  input  wire logic [1:0]       combined_control_sel_in,
  input  wire logic             config_done_in,
  input  wire logic             self_power_detect_used_in,
  input  wire logic [1:0]       fixed_device_cfg_in,
  output logic [1:0]            overcurrent_out,
  output logic [1:0]            charging_enable_out,
  output logic                  self_powered_out,
  output logic [1:0]            fixed_device_out,
  output logic                  configuring_out,
  // Pins
  input  wire logic             self_power_detect_in,
  input  wire logic [1:0]       fixed_device_straps_in,
  input  wire logic             port1_charging_strap_in,
  input  wire logic             port2_charging_strap_in,
  input  wire logic             port1_overcurrent_sense_n_in,
  input  wire logic             port2_overcurrent_sense_n_in,
  input  wire logic             port1_combined_control_in,
  input  wire logic             port2_combined_control_in,
  output logic                  port1_power_enable_out,
  output logic                  port1_power_enable_oe_out,
  output logic                  port2_power_enable_out,
  output logic                  port2_power_enable_oe_out
);
  import ppsl_pkg::*;

  // ============================================================
  // Input synchronisers
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;

  assign async_in = {port2_combined_control_in, port1_combined_control_in,
                     fixed_device_straps_in, port2_charging_strap_in,
                     port1_charging_strap_in, port2_overcurrent_sense_n_in,
                     port1_overcurrent_sense_n_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          sync1_reg[gi] <= 1'b1;
          sync2_reg[gi] <= 1'b1;
        end else begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic lp_sync1_reg;
  logic lp_sync2_reg;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lp_sync1_reg <= 1'b0;
      lp_sync2_reg <= 1'b0;
    end else begin
      lp_sync1_reg <= self_power_detect_in;
      lp_sync2_reg <= lp_sync1_reg;
    end
  end

  // ============================================================
  // Stage sequencing: strap capture waits until the second synchroniser
  // stage holds a real pin sample, never the flops' reset value
  ppsl_state_e state_reg;
  logic        sync_warm_reg;
  logic        sync_full_reg;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg     <= PPSL_RESET_ST;
      sync_warm_reg <= 1'b0;
      sync_full_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        PPSL_RESET_ST: begin
          sync_warm_reg <= 1'b1;
          sync_full_reg <= sync_warm_reg;
          if (sync_full_reg) begin
            state_reg <= PPSL_CONFIG_ST;
          end
        end
        PPSL_CONFIG_ST: begin
          if (config_done_in) begin
            state_reg <= PPSL_RUN_ST;
          end
        end
        PPSL_RUN_ST: begin
          state_reg <= PPSL_RUN_ST;
        end
        default: begin
          state_reg <= PPSL_RESET_ST;
        end
      endcase
    end
  end

  logic capture;
  assign capture         = (state_reg == PPSL_RESET_ST) && sync_full_reg;
  assign configuring_out = (state_reg == PPSL_CONFIG_ST);

  // ============================================================
  // Strap latches
  logic [1:0] charging_reg;
  logic [1:0] fixed_strap_reg;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      charging_reg    <= {2{`PPSL_STRAP_DISABLED}};
      fixed_strap_reg <= 2'h0;
    end else if (capture) begin
      charging_reg    <= sync2_reg[3:2];
      fixed_strap_reg <= sync2_reg[5:4];
    end
  end
  assign charging_enable_out = charging_reg;

  // Strap ignored when self-power detect shares its pin
  assign fixed_device_out = self_power_detect_used_in ? fixed_device_cfg_in
                                                      : fixed_strap_reg;

  // ============================================================
  // Dynamic-power register; management port wins on a collision
  ppsl_byte_t dyn_pwr_reg;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dyn_pwr_reg <= `PPSL_DYN_PWR_RESET;
    end else if (smbus_wr_in && smbus_addr_in == `PPSL_DYN_PWR_ADDR) begin
      dyn_pwr_reg <= smbus_wdata_in;
    end else if (otp_wr_in && otp_addr_in == `PPSL_DYN_PWR_ADDR) begin
      dyn_pwr_reg <= otp_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_out <= 8'h00;
    end else if (rd_in) begin
      rd_data_out <= (rd_addr_in == `PPSL_DYN_PWR_ADDR) ? dyn_pwr_reg : 8'h00;
    end
  end

  // ============================================================
  // Self-power latch
  logic dynamic_on;
  logic self_pwr_reg;
  assign dynamic_on = (dyn_pwr_reg == `PPSL_DYN_PWR_ENABLE);
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      self_pwr_reg <= 1'b0;
    end else if (state_reg == PPSL_CONFIG_ST) begin
      self_pwr_reg <= lp_sync2_reg;
    end else if (state_reg == PPSL_RUN_ST && dynamic_on) begin
      self_pwr_reg <= lp_sync2_reg;
    end
  end
  assign self_powered_out = (self_pwr_reg == `PPSL_SELF_POWERED);

  // ============================================================
  // Power enables and over-current. Combined pins are open drain:
  // power on releases the pin, off pulls it low, and the pulled-up
  // level read back low while released means over-current.
  logic [1:0] pwr_reg;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pwr_reg <= {2{`PPSL_PWR_OFF}};
    end else if (state_reg == PPSL_RUN_ST) begin
      pwr_reg <= port_power_request_in;
    end else begin
      pwr_reg <= {2{`PPSL_PWR_OFF}};
    end
  end

  always_comb begin
    port1_power_enable_out = combined_control_sel_in[0] ? 1'b0 : pwr_reg[0];
    port1_power_enable_oe_out = combined_control_sel_in[0]
                              ? (pwr_reg[0] == `PPSL_PWR_OFF) : 1'b1;
    port2_power_enable_out = combined_control_sel_in[1] ? 1'b0 : pwr_reg[1];
    port2_power_enable_oe_out = combined_control_sel_in[1]
                              ? (pwr_reg[1] == `PPSL_PWR_OFF) : 1'b1;
  end

  // Readback lags a release by the synchroniser depth; wait it out so
  // the pull-low of the off state is not taken for over-current
  logic [1:0] pwr_d1_reg;
  logic [1:0] pwr_d2_reg;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pwr_d1_reg <= {2{`PPSL_PWR_OFF}};
      pwr_d2_reg <= {2{`PPSL_PWR_OFF}};
    end else begin
      pwr_d1_reg <= pwr_reg;
      pwr_d2_reg <= pwr_d1_reg;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      overcurrent_out <= 2'h0;
    end else begin
      overcurrent_out[0] <= combined_control_sel_in[0]
                          ? (pwr_reg[0] && pwr_d2_reg[0] && !sync2_reg[6])
                          : !sync2_reg[0];
      overcurrent_out[1] <= combined_control_sel_in[1]
                          ? (pwr_reg[1] && pwr_d2_reg[1] && !sync2_reg[7])
                          : !sync2_reg[1];
    end
  end
endmodule
